// >>> acsr_pkg.sv
package acsr_pkg;

    // Result word and buffering
    localparam int unsigned RESULT_W   = 16;
    localparam int unsigned FIFO_DEPTH = 8;

    // Timing
    localparam int unsigned CLK_MHZ      = 40;
    localparam int unsigned CONV_TIME_NS = 322;
    // Longest time, so rounded down
    localparam int unsigned CONV_CYCLES_I = (CONV_TIME_NS * CLK_MHZ) / 1000;
    localparam int unsigned CNT_W         = 8;
    localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYCLES_I - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO  = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ONE   = 8'h01;

    // Pin levels
    localparam logic OE_DRIVE = 1'b0;
    localparam logic OE_FLOAT = 1'b1;

    // Synchronised pin vector layout
    localparam int unsigned PIN_TRIG  = 0;
    localparam int unsigned PIN_CHAIN = 1;
    localparam int unsigned PIN_GATE  = 2;
    localparam int unsigned PIN_CNT   = 3;

    typedef enum logic [1:0] {
        ACSR_IDLE,
        ACSR_CONV,
        ACSR_FETCH
    } acsr_state_t;

endpackage

// >>> acsr_sync.sv
module acsr_sync #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input  wire logic         clock_i,
    input  wire logic         rstn_i,
    // Asynchronous level in, synchronised level out
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;
    logic [W-1:0] nxt_meta;
    logic [W-1:0] nxt_q;

    always_comb begin
        nxt_meta = rstn_i ? d_i : '0;
        nxt_q    = rstn_i ? meta_ff : '0;
    end

    always_ff @(posedge clock_i) begin
        meta_ff <= nxt_meta;
        q_ff    <= nxt_q;
    end

    assign q_o = q_ff;

endmodule

// >>> acsr_fifo.sv
module acsr_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clock_i,
    input  wire logic             rstn_i,
    // Filling side
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    // Draining side
    output logic      [WIDTH-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);

    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [WIDTH-1:0] nxt_mem [DEPTH];
    logic [AW:0]      wr_ptr_ff;
    logic [AW:0]      rd_ptr_ff;
    logic [AW:0]      nxt_wr_ptr;
    logic [AW:0]      nxt_rd_ptr;
    logic             full;
    logic             empty;
    logic             push;
    logic             pop;

    assign empty       = (wr_ptr_ff == rd_ptr_ff);
    assign full        = (wr_ptr_ff[AW] != rd_ptr_ff[AW])
                         && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
    assign in_ready_o  = ~full;
    assign out_valid_o = ~empty;
    assign out_data_o  = mem_ff[rd_ptr_ff[AW-1:0]];
    assign push        = in_valid_i & ~full;
    assign pop         = out_ready_i & ~empty;

    always_comb begin
        nxt_mem    = mem_ff;
        nxt_wr_ptr = wr_ptr_ff;
        nxt_rd_ptr = rd_ptr_ff;
        if (push) begin
            nxt_mem[wr_ptr_ff[AW-1:0]] = in_data_i;
            nxt_wr_ptr                 = wr_ptr_ff + (AW+1)'(1);
        end
        if (pop) begin
            nxt_rd_ptr = rd_ptr_ff + (AW+1)'(1);
        end
        if (!rstn_i) begin
            nxt_wr_ptr = '0;
            nxt_rd_ptr = '0;
        end
    end

    always_ff @(posedge clock_i) begin
        mem_ff    <= nxt_mem;
        wr_ptr_ff <= nxt_wr_ptr;
        rd_ptr_ff <= nxt_rd_ptr;
    end

endmodule

// >>> acsr_readout.sv
module acsr_readout
    import acsr_pkg::*;
#(
    parameter int unsigned WIDTH = acsr_pkg::RESULT_W,
    parameter int unsigned DEPTH = acsr_pkg::FIFO_DEPTH
) (
    // System clock and reset
    input  wire logic             clock_i,
    input  wire logic             rstn_i,
    // Link shift clock
    input  wire logic             sck_i,
    // Control pins
    input  wire logic             convert_trigger_i,
    input  wire logic             chain_sel_i,
    input  wire logic             read_gate_or_serial_in_i,
    // Sample stream from the converter core
    input  wire logic [WIDTH-1:0] sample_data_i,
    input  wire logic             sample_valid_i,
    output logic                  sample_ready_o,
    // Status and serial output pins
    output logic                  busy_o,
    output logic                  sdo_o,
    output logic                  sdo_oe_n_o
);

    import acsr_pkg::*;

    // System-clock domain
    logic [PIN_CNT-1:0] pins_async;
    logic [PIN_CNT-1:0] pins_s;
    logic               trig_s;
    logic               chain_s;
    logic               gate_s;
    logic               trig_prev_ff;
    logic               nxt_trig_prev;
    logic               trig_rise;

    acsr_state_t        state_ff;
    acsr_state_t        nxt_state;
    logic [CNT_W-1:0]   cnt_ff;
    logic [CNT_W-1:0]   nxt_cnt;
    logic [WIDTH-1:0]   word_ff;
    logic [WIDTH-1:0]   nxt_word;
    logic               word_tgl_ff;
    logic               nxt_word_tgl;
    logic               busy_ff;
    logic               nxt_busy;
    logic               oe_n_ff;
    logic               nxt_oe_n;

    logic [WIDTH-1:0]   fifo_data;
    logic               fifo_valid;
    logic               fifo_ready;

    // Link domain
    logic               srst_n;
    logic [WIDTH-1:0]   shreg_ff;
    logic [WIDTH-1:0]   nxt_shreg;
    logic               used_tgl_ff;
    logic               nxt_used_tgl;
    logic               fresh;

    assign pins_async[PIN_TRIG]  = convert_trigger_i;
    assign pins_async[PIN_CHAIN] = chain_sel_i;
    // Synced as an enable: the cleared synchroniser then reads floating
    assign pins_async[PIN_GATE]  = ~read_gate_or_serial_in_i;

    acsr_sync #(
        .W (PIN_CNT)
    ) u_pin_sync (
        .clock_i (clock_i),
        .rstn_i  (rstn_i),
        .d_i     (pins_async),
        .q_o     (pins_s)
    );

    assign trig_s  = pins_s[PIN_TRIG];
    assign chain_s = pins_s[PIN_CHAIN];
    assign gate_s  = ~pins_s[PIN_GATE];

    // Stream buffer; its ready back-pressures the core
    acsr_fifo #(
        .WIDTH (WIDTH),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clock_i     (clock_i),
        .rstn_i      (rstn_i),
        .in_data_i   (sample_data_i),
        .in_valid_i  (sample_valid_i),
        .in_ready_o  (sample_ready_o),
        .out_data_o  (fifo_data),
        .out_valid_o (fifo_valid),
        .out_ready_i (fifo_ready)
    );

    assign trig_rise  = trig_s & ~trig_prev_ff;
    assign fifo_ready = (state_ff == ACSR_FETCH);

    // Conversion sequencer
    always_comb begin
        nxt_trig_prev = trig_s;
        nxt_state     = state_ff;
        nxt_cnt       = cnt_ff;
        nxt_word      = word_ff;
        nxt_word_tgl  = word_tgl_ff;
        nxt_busy      = busy_ff;
        case (state_ff)
            ACSR_IDLE: begin
                // Edges while busy are ignored, not queued
                if (trig_rise) begin
                    nxt_state = ACSR_CONV;
                    nxt_cnt   = CONV_LAST;
                    nxt_busy  = 1'b1;
                end
            end
            ACSR_CONV: begin
                if (cnt_ff == CNT_ZERO) begin
                    nxt_state = ACSR_FETCH;
                end else begin
                    nxt_cnt = cnt_ff - CNT_ONE;
                end
            end
            ACSR_FETCH: begin
                // Busy stretches until the core has a word
                if (fifo_valid) begin
                    nxt_word     = fifo_data;
                    nxt_word_tgl = ~word_tgl_ff;
                    nxt_busy     = 1'b0;
                    nxt_state    = ACSR_IDLE;
                end
            end
            default: begin
                nxt_state = ACSR_IDLE;
                nxt_busy  = 1'b0;
            end
        endcase
        if (!rstn_i) begin
            nxt_trig_prev = 1'b0;
            nxt_state     = ACSR_IDLE;
            nxt_cnt       = CNT_ZERO;
            nxt_word      = '0;
            nxt_word_tgl  = 1'b0;
            nxt_busy      = 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        trig_prev_ff <= nxt_trig_prev;
        state_ff     <= nxt_state;
        cnt_ff       <= nxt_cnt;
        word_ff      <= nxt_word;
        word_tgl_ff  <= nxt_word_tgl;
        busy_ff      <= nxt_busy;
    end

    // Output enable: chain mode always drives, else the gate decides
    always_comb begin
        if (!rstn_i) begin
            nxt_oe_n = OE_FLOAT;
        end else if (chain_s) begin
            nxt_oe_n = OE_DRIVE;
        end else if (gate_s) begin
            nxt_oe_n = OE_FLOAT;
        end else begin
            nxt_oe_n = OE_DRIVE;
        end
    end

    always_ff @(posedge clock_i) begin
        oe_n_ff <= nxt_oe_n;
    end

    assign busy_o     = busy_ff;
    assign sdo_oe_n_o = oe_n_ff;

    // Link-domain reset; needs a few shift clocks while held
    acsr_sync #(
        .W (1)
    ) u_srst_sync (
        .clock_i (sck_i),
        .rstn_i  (1'b1),
        .d_i     (rstn_i),
        .q_o     (srst_n)
    );

    // The word and its toggle change only at conversion end, while the
    // host keeps the shift clock still, so they are quasi-static here.
    assign fresh = (word_tgl_ff != used_tgl_ff);

    always_comb begin
        nxt_used_tgl = word_tgl_ff;
        if (fresh) begin
            // First edge: upstream top bit lands behind the result
            nxt_shreg = {word_ff[WIDTH-2:0], read_gate_or_serial_in_i};
        end else begin
            nxt_shreg = {shreg_ff[WIDTH-2:0], read_gate_or_serial_in_i};
        end
        if (!srst_n) begin
            nxt_shreg    = '0;
            nxt_used_tgl = 1'b0;
        end
    end

    always_ff @(posedge sck_i) begin
        shreg_ff    <= nxt_shreg;
        used_tgl_ff <= nxt_used_tgl;
    end

    // Until the first rising edge the fresh word's top bit is shown
    assign sdo_o = fresh ? word_ff[WIDTH-1] : shreg_ff[WIDTH-1];
    // The gate enables the driver of an already valid top bit

endmodule

// >>> acsr_readout_asserts.sv
module acsr_readout_asserts
    import acsr_pkg::*;
#(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 8
) (
    // Clock and reset
    input wire logic             clock_i,
    input wire logic             rstn_i,
    // Link and control pins
    input wire logic             sck_i,
    input wire logic             convert_trigger_i,
    input wire logic             chain_sel_i,
    input wire logic             read_gate_or_serial_in_i,
    // Sample stream
    input wire logic [WIDTH-1:0] sample_data_i,
    input wire logic             sample_valid_i,
    input wire logic             sample_ready_o,
    // Status and output pins
    input wire logic             busy_o,
    input wire logic             sdo_o,
    input wire logic             sdo_oe_n_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rstn_i);

    busy_len_a: assert property ($rose(busy_o) |=> busy_o [*8] ##1 busy_o [*4])
        else $error("busy ended before the conversion time");
    busy_start_a: assert property ($rose(convert_trigger_i) && !busy_o |-> ##[2:5] busy_o)
        else $error("trigger rise did not start a conversion");
    busy_cause_a: assert property ($rose(busy_o) |-> $past(convert_trigger_i, 2))
        else $error("busy rose without a trigger");
    float_normal_a: assert property ((!chain_sel_i && read_gate_or_serial_in_i) [*4]
        |-> sdo_oe_n_o == OE_FLOAT) else $error("output driven while gate high");
    drive_normal_a: assert property ((!chain_sel_i && !read_gate_or_serial_in_i) [*4]
        |-> sdo_oe_n_o == OE_DRIVE) else $error("output floating while gate low");
    chain_drive_a: assert property (chain_sel_i [*4] |-> sdo_oe_n_o == OE_DRIVE)
        else $error("output floating in chain mode");
    sdo_change_a: assert property ($changed(sdo_o) |-> $rose(sck_i) || $fell(busy_o))
        else $error("serial output changed without a shift edge");
    ready_pop_a: assert property ($rose(sample_ready_o) |-> $fell(busy_o))
        else $error("buffer space freed without a conversion end");

    chain_end_c: cover property ($fell(busy_o) && chain_sel_i);
    normal_end_c: cover property ($fell(busy_o) && !chain_sel_i);
    full_c: cover property (!sample_ready_o && sample_valid_i);
endmodule

bind acsr_readout acsr_readout_asserts #(.WIDTH(WIDTH), .DEPTH(DEPTH)) i_chk (
    .clock_i(clock_i), .rstn_i(rstn_i), .sck_i(sck_i),
    .convert_trigger_i(convert_trigger_i), .chain_sel_i(chain_sel_i),
    .read_gate_or_serial_in_i(read_gate_or_serial_in_i), .sample_data_i(sample_data_i),
    .sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o),
    .busy_o(busy_o), .sdo_o(sdo_o), .sdo_oe_n_o(sdo_oe_n_o));

// >>> acsr_host_model.sv
module acsr_host_model (
    // Frame control
    input  wire logic        start_i,
    input  wire logic [5:0]  edges_i,
    input  wire logic [15:0] up_word_i,
    // Link pins
    input  wire logic        sdo_i,
    output logic             sck_o,
    output logic             sdi_o,
    // Captured frame
    output logic [31:0]      got_o,
    output logic             done_o
);
    timeunit 1ns;
    timeprecision 100ps;
    int k;
    initial begin
        sck_o = 1'h0;
        sdi_o = 1'h0;
        got_o = 32'h0000_0000;
        done_o = 1'h0;
    end
    // Shift clock stands low between frames
    always @(posedge start_i) begin
        done_o = 1'h0;
        got_o = 32'h0000_0000;
        sdi_o = up_word_i[15];
        #7;
        for (k = 1; k <= int'(edges_i); k++) begin
            got_o = {got_o[30:0], sdo_i};
            #62.5 sck_o = 1'h1;
            // Upstream shifts after its rise, so the hold time is met
            #1 sdi_o = (k < 16) ? up_word_i[15-k] : ~sdi_o;
            #61.5 sck_o = 1'h0;
        end
        done_o = 1'h1;
    end
endmodule

// >>> adc_serial_readout_chain_test.sv
module adc_serial_readout_chain_test;
    import acsr_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clock_i, rstn_i, trig, chain, gate_n, valid, h_start;
    logic [15:0] data, up;
    logic [5:0]  h_n;
    logic [15:0] wq [9];
    logic [31:0] exp_q [$];
    logic [31:0] h_got;
    logic        h_sck, l_sck, sdi, ready, busy, sdo, oe_n, h_done;
    int          errors, check_count, cycles, i;
    wire logic   rg = chain ? sdi : gate_n;
    wire logic   sck = h_sck | l_sck;

    acsr_readout i_dut (.clock_i(clock_i), .rstn_i(rstn_i), .sck_i(sck),
        .convert_trigger_i(trig), .chain_sel_i(chain), .read_gate_or_serial_in_i(rg),
        .sample_data_i(data), .sample_valid_i(valid), .sample_ready_o(ready),
        .busy_o(busy), .sdo_o(sdo), .sdo_oe_n_o(oe_n));
    // A floating output reads back inverted, so a missing drive shows
    acsr_host_model i_host (.start_i(h_start), .edges_i(h_n), .up_word_i(up),
        .sdo_i(oe_n ? ~sdo : sdo), .sck_o(h_sck), .sdi_o(sdi), .got_o(h_got),
        .done_o(h_done));

    initial begin
        clock_i = 1'h0;
        forever #12.5 clock_i = ~clock_i;
    end
    // Link side resets on its own clock, so it ticks around the resets
    initial begin
        l_sck = 1'h0;
        #5;
        repeat (11) begin
            #62.5 l_sck = 1'h1;
            #62.5 l_sck = 1'h0;
        end
    end
    task finish_test;
        if (exp_q.size() != 0) errors++;
        if (errors == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Trigger only while idle; optional late word tests the empty-buffer stretch
    task conv(input logic fill);
        int k;
        @(negedge clock_i) trig = 1'h1;
        repeat (6) @(negedge clock_i);
        trig = 1'h0;
        if (fill) begin
            repeat (20) @(negedge clock_i);
            chk(busy, 32'h0000_0001);
            data = wq[8];
            valid = 1'h1;
            @(negedge clock_i) valid = 1'h0;
        end
        for (k = 0; k < 100 && busy !== 1'h0; k++) @(negedge clock_i);
        chk(busy, 32'h0000_0000);
        repeat (2) @(negedge clock_i);
    endtask
    task read(input int n, input logic [31:0] e);
        int k;
        exp_q.push_back(e);
        h_n = 6'(n);
        h_start = 1'h1;
        @(negedge clock_i) h_start = 1'h0;
        for (k = 0; k < 400 && h_done !== 1'h1; k++) @(negedge clock_i);
        @(negedge clock_i);
    endtask
    always @(posedge h_done) chk(h_got, exp_q.pop_front());
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 10000) begin
            errors++;
            finish_test;
        end
    end

    initial begin
        {rstn_i, trig, chain, valid, h_start} = 5'h00;
        gate_n = 1'h1;
        data = 16'h0000;
        up = 16'h0000;
        h_n = 6'h10;
        void'($urandom(32'h21b7_4a9b));
        for (i = 0; i < 9; i++) wq[i] = 16'($urandom);
        repeat (5) @(negedge clock_i);
        rstn_i = 1'h1;
        chk({busy, oe_n, ready}, 32'h0000_0003);
        repeat (2) @(negedge clock_i);
        chk(oe_n, 32'h0000_0001);
        // Second reset, long enough for the link side to see its clock
        rstn_i = 1'h0;
        repeat (30) @(negedge clock_i);
        rstn_i = 1'h1;
        repeat (2) @(negedge clock_i);
        chk({busy, oe_n, ready}, 32'h0000_0003);
        repeat (20) @(negedge clock_i);
        for (i = 0; i < 9; i++) begin
            @(negedge clock_i) data = wq[i];
            valid = 1'h1;
            if (i == 8) chk(ready, 32'h0000_0000);
        end
        valid = 1'h0;
        conv(1'h0);
        chk(oe_n, 32'h0000_0001);
        gate_n = 1'h0;
        repeat (3) @(negedge clock_i);
        chk({oe_n, sdo, ready}, {29'h0000_0000, 1'h0, wq[0][15], 1'h1});
        read(16, {16'h0000, wq[0]});
        for (i = 1; i < 6; i++) begin
            conv(1'h0);
            chk(sdo, wq[i][15]);
            read(16, {16'h0000, wq[i]});
        end
        chain = 1'h1;
        for (i = 6; i < 8; i++) begin
            up = 16'($urandom);
            conv(1'h0);
            chk(oe_n, 32'h0000_0000);
            read(32, {wq[i], up});
        end
        chain = 1'h0;
        conv(1'h1);
        chk(sdo, wq[8][15]);
        read(16, {16'h0000, wq[8]});
        finish_test;
    end
endmodule
